//--- hdl/fip_seq.sv
// command sequencer, status flags, id mode and protection of the flash
`include "fip_map.svh"
`default_nettype none
module fip_seq #(
	parameter int SECT_ERASE_CYC = `FIP_CYC_SECT,
	parameter int CHIP_ERASE_CYC = `FIP_CYC_CHIP,
	parameter logic [7:0] VENDOR_CODE = 8'h5A, // arbitrary value
	parameter logic [7:0] MACRO_CODE = 8'h11, // arbitrary value
	parameter logic [7:0] SIZE_CODE = 8'h22 // arbitrary value
) (
	input wire logic I_CLOCK,
	input wire logic I_RST_N,
	input wire logic [`FIP_AW-1:0] I_ADDR,
	input wire logic [`FIP_DW-1:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic I_BYTE,
	output logic [`FIP_DW-1:0] O_RDATA,
	input wire logic I_PGMR_MODE,
	input wire logic I_BOOT_MODE,
	output logic O_PGMR_RD_BLOCK,
	output logic O_PGMR_WR_BLOCK,
	output logic O_BOOT_CMD_BLOCK,
	output logic O_BOOTROM_OVER_VECT,
	output logic O_FLASH_ALT_MAP,
	output logic [`FIP_AW-1:0] O_ARR_ADDR,
	input wire logic [`FIP_DW-1:0] I_ARR_DATA,
	output logic O_ARR_PGM,
	output logic [`FIP_AW-1:0] O_ARR_PGM_ADDR,
	output logic [`FIP_DW-1:0] O_ARR_PGM_DATA,
	output logic O_ARR_SECT_ERASE,
	output logic [`FIP_SECT_HI-`FIP_SECT_LO:0] O_ARR_SECT,
	output logic O_ARR_CHIP_ERASE,
	output logic O_BUSY,
	output logic O_ID_MODE,
	output logic O_READ_PROT,
	output logic O_WRITE_PROT
);
	fip_pkg::fip_state_t st_r;
	fip_pkg::fip_state_t st_nxt;
	fip_pkg::fip_op_t op_r;
	fip_pkg::fip_op_t op_nxt;
	fip_pkg::fip_cnt_t cnt_r;
	fip_pkg::fip_cnt_t start_cnt;
	logic busy_r;
	logic settle_r;
	logic tgl_r;
	logic id_mode_r;
	logic rprot_r;
	logic wprot_r;
	logic prot_rd_r;
	logic prot_rd_nxt;
	logic start;
	logic id_set;
	logic id_clr;
	logic [`FIP_DW-1:0] rdata_r;
	logic [`FIP_DW-1:0] rd_word;
	logic [`FIP_AW-1:0] pgm_addr_r;
	logic [`FIP_DW-1:0] pgm_data_r;
	logic [`FIP_SECT_HI-`FIP_SECT_LO:0] sect_r;
	logic arr_pgm_r;
	logic arr_sect_r;
	logic arr_chip_r;

	function automatic logic [`FIP_DW-1:0] lane(input logic [`FIP_DW-1:0] w,
			input logic byte_sel, input logic odd);
		if (byte_sel && odd)
			lane = {8'h00, w[15:8]};
		else if (byte_sel)
			lane = {8'h00, w[7:0]};
		else
			lane = w;
	endfunction

	wire [7:0] wd = I_WDATA[7:0];
	wire a_cmd1 = I_ADDR[11:0] == `FIP_A_CMD1;
	wire a_cmd2 = I_ADDR[11:0] == `FIP_A_CMD2;
	wire a_prot = I_ADDR[11:0] == `FIP_A_PROT;
	wire busy_any = busy_r || settle_r;
	wire done = busy_r && (cnt_r == fip_pkg::fip_cnt_t'(1));
	wire settle_done = settle_r && (cnt_r == fip_pkg::fip_cnt_t'(1));
	wire pgmr_rd_block = I_PGMR_MODE && rprot_r;
	wire pgmr_wr_block = I_PGMR_MODE && wprot_r;
	wire is_erase = (op_r == fip_pkg::FIP_OP_SECT) ||
		(op_r == fip_pkg::FIP_OP_CHIP);
	// bit 7 is useless for protect set, so it reads 0 there
	wire poll_d7 = (op_r == fip_pkg::FIP_OP_PGM) ?
		~pgm_data_r[`FIP_D7] : 1'b0;
	wire [7:0] prot_stat = {{4{~rprot_r}}, {4{~wprot_r}}};
	wire [7:0] id_byte = a_prot ? prot_stat :
		(I_ADDR[7:0] == `FIP_A_VENDOR) ? VENDOR_CODE :
		(I_ADDR[7:0] == `FIP_A_MACRO) ? MACRO_CODE :
		(I_ADDR[7:0] == `FIP_A_SIZE) ? SIZE_CODE : 8'h00;
	wire [7:0] busy_byte = (8'h01 << `FIP_D7) & {8{poll_d7}} |
		(8'h01 << `FIP_D6) & {8{tgl_r}};
	wire [7:0] settle_byte = 8'h01 << `FIP_D7;

	// array contents never leave while busy, in id mode or when blocked
	assign rd_word = busy_r ? {8'h00, busy_byte} :
		settle_r ? {8'h00, settle_byte} :
		id_mode_r ? {8'h00, id_byte} :
		pgmr_rd_block ? {`FIP_DW{1'b0}} :
		lane(I_ARR_DATA, I_BYTE, I_ADDR[0]);

	assign start_cnt = (op_nxt == fip_pkg::FIP_OP_PGM) ?
		fip_pkg::fip_cnt_t'(`FIP_CYC_PGM) :
		(op_nxt == fip_pkg::FIP_OP_SECT) ?
		fip_pkg::fip_cnt_t'(SECT_ERASE_CYC) :
		(op_nxt == fip_pkg::FIP_OP_CHIP) ?
		fip_pkg::fip_cnt_t'(CHIP_ERASE_CYC) :
		fip_pkg::fip_cnt_t'(`FIP_CYC_PROT);

	always_comb begin
		st_nxt = st_r;
		op_nxt = op_r;
		prot_rd_nxt = prot_rd_r;
		start = 1'b0;
		id_set = 1'b0;
		id_clr = 1'b0;
		// writes during an automatic operation are ignored
		if (I_WR && !busy_any) begin
			st_nxt = fip_pkg::FIP_S_IDLE;
			case (st_r)
				fip_pkg::FIP_S_IDLE: begin
					if (a_cmd1 && wd == `FIP_D_UNLK1)
						st_nxt = fip_pkg::FIP_S_UNLK1;
					else if (wd == `FIP_D_EXIT)
						id_clr = 1'b1;
				end
				fip_pkg::FIP_S_UNLK1: begin
					if (a_cmd2 && wd == `FIP_D_UNLK2)
						st_nxt = fip_pkg::FIP_S_UNLK2;
				end
				fip_pkg::FIP_S_UNLK2: begin
					if (a_cmd1) begin
						case (wd)
							`FIP_D_PGM: st_nxt = fip_pkg::FIP_S_PGM;
							`FIP_D_ERASE: st_nxt = fip_pkg::FIP_S_ERA3;
							`FIP_D_PROT: st_nxt = fip_pkg::FIP_S_PROT;
							`FIP_D_ID: id_set = 1'b1;
							`FIP_D_EXIT: id_clr = 1'b1;
							default: st_nxt = fip_pkg::FIP_S_IDLE;
						endcase
					end
				end
				fip_pkg::FIP_S_ERA3: begin
					if (a_cmd1 && wd == `FIP_D_UNLK1)
						st_nxt = fip_pkg::FIP_S_ERA4;
				end
				fip_pkg::FIP_S_ERA4: begin
					if (a_cmd2 && wd == `FIP_D_UNLK2)
						st_nxt = fip_pkg::FIP_S_ERA5;
				end
				fip_pkg::FIP_S_ERA5: begin
					// sector erase is not offered in programmer mode
					if (wd == `FIP_D_SECT && !I_PGMR_MODE) begin
						start = 1'b1;
						op_nxt = fip_pkg::FIP_OP_SECT;
					end else if (a_cmd1 && wd == `FIP_D_CHIP) begin
						start = 1'b1;
						op_nxt = fip_pkg::FIP_OP_CHIP;
					end
				end
				fip_pkg::FIP_S_PGM: begin
					if (!pgmr_wr_block) begin
						start = 1'b1;
						op_nxt = fip_pkg::FIP_OP_PGM;
					end
				end
				fip_pkg::FIP_S_PROT: begin
					if (a_prot && (wd == `FIP_D_RPROT ||
							wd == `FIP_D_WPROT)) begin
						start = 1'b1;
						op_nxt = fip_pkg::FIP_OP_PROT;
						prot_rd_nxt = wd == `FIP_D_RPROT;
					end
				end
				default: st_nxt = fip_pkg::FIP_S_IDLE;
			endcase
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			st_r <= fip_pkg::FIP_S_IDLE;
			op_r <= fip_pkg::FIP_OP_PGM;
			prot_rd_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			op_r <= op_nxt;
			prot_rd_r <= prot_rd_nxt;
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			busy_r <= 1'b0;
			settle_r <= 1'b0;
			cnt_r <= '0;
		end else if (start) begin
			busy_r <= 1'b1;
			cnt_r <= start_cnt;
		end else if (done) begin
			busy_r <= 1'b0;
			settle_r <= is_erase;
			cnt_r <= fip_pkg::fip_cnt_t'(`FIP_CYC_SETTLE);
		end else if (settle_done) begin
			settle_r <= 1'b0;
		end else if (busy_any) begin
			cnt_r <= cnt_r - fip_pkg::fip_cnt_t'(1);
		end
	end

	// toggle flips only on reads, so polling software sees each change
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N)
			tgl_r <= 1'b0;
		else if (start)
			tgl_r <= 1'b1;
		else if (I_RD && busy_r)
			tgl_r <= ~tgl_r;
		else if (!busy_r)
			tgl_r <= 1'b0;
	end

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N)
			id_mode_r <= 1'b0;
		else if (id_set)
			id_mode_r <= 1'b1;
		else if (id_clr)
			id_mode_r <= 1'b0;
	end

	// volatile model of the protect cells: set only on protect completion
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rprot_r <= 1'b0;
			wprot_r <= 1'b0;
		end else if (done && op_r == fip_pkg::FIP_OP_CHIP) begin
			rprot_r <= 1'b0;
			wprot_r <= 1'b0;
		end else if (done && op_r == fip_pkg::FIP_OP_PROT) begin
			rprot_r <= rprot_r | prot_rd_r;
			wprot_r <= wprot_r | ~prot_rd_r;
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			pgm_addr_r <= '0;
			pgm_data_r <= '0;
			sect_r <= '0;
		end else if (start) begin
			pgm_addr_r <= I_ADDR;
			pgm_data_r <= I_WDATA;
			sect_r <= I_ADDR[`FIP_SECT_HI:`FIP_SECT_LO];
		end
	end

	// array strobes last one cycle; the macro fills erased bytes with ones
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			arr_pgm_r <= 1'b0;
			arr_sect_r <= 1'b0;
			arr_chip_r <= 1'b0;
		end else begin
			arr_pgm_r <= start && op_nxt == fip_pkg::FIP_OP_PGM;
			arr_sect_r <= start && op_nxt == fip_pkg::FIP_OP_SECT;
			arr_chip_r <= start && op_nxt == fip_pkg::FIP_OP_CHIP;
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N)
			rdata_r <= '0;
		else if (I_RD)
			rdata_r <= rd_word;
	end

	assign O_RDATA = rdata_r;
	assign O_ARR_ADDR = I_ADDR;
	assign O_ARR_PGM = arr_pgm_r;
	assign O_ARR_PGM_ADDR = pgm_addr_r;
	assign O_ARR_PGM_DATA = pgm_data_r;
	assign O_ARR_SECT_ERASE = arr_sect_r;
	assign O_ARR_SECT = sect_r;
	assign O_ARR_CHIP_ERASE = arr_chip_r;
	assign O_PGMR_RD_BLOCK = pgmr_rd_block;
	assign O_PGMR_WR_BLOCK = pgmr_wr_block;
	assign O_BOOT_CMD_BLOCK = I_BOOT_MODE && (rprot_r || wprot_r);
	assign O_BOOTROM_OVER_VECT = I_BOOT_MODE;
	assign O_FLASH_ALT_MAP = I_BOOT_MODE;
	assign O_BUSY = busy_any;
	assign O_ID_MODE = id_mode_r;
	assign O_READ_PROT = rprot_r;
	assign O_WRITE_PROT = wprot_r;
endmodule
`default_nettype wire

//--- common/fip_map.svh
// address, data and timing constants of the flash sequencer
`ifndef FIP_MAP_SVH
`define FIP_MAP_SVH
`define FIP_AW 24
`define FIP_DW 16
`define FIP_A_CMD1 12'hAAA
`define FIP_A_CMD2 12'h554
`define FIP_A_PROT 12'h77E
`define FIP_A_VENDOR 8'h00
`define FIP_A_MACRO 8'h02
`define FIP_A_SIZE 8'h04
`define FIP_D_UNLK1 8'hAA
`define FIP_D_UNLK2 8'h55
`define FIP_D_PGM 8'hA0
`define FIP_D_ERASE 8'h80
`define FIP_D_ID 8'h90
`define FIP_D_EXIT 8'hF0
`define FIP_D_PROT 8'hA5
`define FIP_D_SECT 8'h30
`define FIP_D_CHIP 8'h10
`define FIP_D_RPROT 8'hF0
`define FIP_D_WPROT 8'h0F
`define FIP_ERASED 8'hFF
`define FIP_D7 7
`define FIP_D6 6
`define FIP_SECT_HI 23
`define FIP_SECT_LO 12
`define FIP_CLK_MHZ 50
`define FIP_T_PGM_US 60
`define FIP_T_PROT_US 60
`define FIP_T_SETTLE_US 1
`define FIP_T_SECT_MS 75
`define FIP_T_CHIP_MS 300
`define FIP_CYC_PGM (`FIP_T_PGM_US * `FIP_CLK_MHZ)
`define FIP_CYC_PROT (`FIP_T_PROT_US * `FIP_CLK_MHZ)
`define FIP_CYC_SETTLE (`FIP_T_SETTLE_US * `FIP_CLK_MHZ)
`define FIP_CYC_SECT (`FIP_T_SECT_MS * 1000 * `FIP_CLK_MHZ)
`define FIP_CYC_CHIP (`FIP_T_CHIP_MS * 1000 * `FIP_CLK_MHZ)
`endif

//--- common/fip_pkg.sv
// types of the flash sequencer
`default_nettype none
package fip_pkg;
	typedef enum logic [7:0] {
		FIP_S_IDLE = 8'h01,
		FIP_S_UNLK1 = 8'h02,
		FIP_S_UNLK2 = 8'h04,
		FIP_S_ERA3 = 8'h08,
		FIP_S_ERA4 = 8'h10,
		FIP_S_ERA5 = 8'h20,
		FIP_S_PGM = 8'h40,
		FIP_S_PROT = 8'h80
	} fip_state_t;
	typedef enum logic [3:0] {
		FIP_OP_PGM = 4'h1,
		FIP_OP_SECT = 4'h2,
		FIP_OP_CHIP = 4'h4,
		FIP_OP_PROT = 4'h8
	} fip_op_t;
	typedef logic [23:0] fip_cnt_t;
endpackage
`default_nettype wire

//--- dv/fip_seq_props.sv
// assertions on the ports of the flash sequencer
`include "fip_map.svh"
`default_nettype none
module fip_seq_props (
	input wire logic I_CLOCK,
	input wire logic I_RST_N,
	input wire logic [`FIP_AW-1:0] I_ADDR,
	input wire logic I_RD,
	input wire logic I_PGMR_MODE,
	input wire logic I_BOOT_MODE,
	input wire logic [`FIP_DW-1:0] O_RDATA,
	input wire logic O_PGMR_RD_BLOCK,
	input wire logic O_PGMR_WR_BLOCK,
	input wire logic O_BOOT_CMD_BLOCK,
	input wire logic O_BOOTROM_OVER_VECT,
	input wire logic O_FLASH_ALT_MAP,
	input wire logic [`FIP_AW-1:0] O_ARR_ADDR,
	input wire logic O_ARR_PGM,
	input wire logic O_BUSY,
	input wire logic O_ID_MODE,
	input wire logic O_READ_PROT,
	input wire logic O_WRITE_PROT
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge I_CLOCK); endclocking
	default disable iff (!I_RST_N);
	a_arr_addr: assert property (O_ARR_ADDR == I_ADDR)
		else $error("array address differs from bus address");
	a_rd_block: assert property (O_PGMR_RD_BLOCK == (I_PGMR_MODE && O_READ_PROT))
		else $error("programmer read block wrong");
	a_wr_block: assert property (O_PGMR_WR_BLOCK == (I_PGMR_MODE && O_WRITE_PROT))
		else $error("programmer write block wrong");
	a_boot_block: assert property (O_BOOT_CMD_BLOCK ==
		(I_BOOT_MODE && (O_READ_PROT || O_WRITE_PROT)))
		else $error("boot command block wrong");
	a_boot_map: assert property ({O_BOOTROM_OVER_VECT, O_FLASH_ALT_MAP} ==
		{2{I_BOOT_MODE}})
		else $error("boot mapping wrong");
	a_pgm_busy: assert property (O_ARR_PGM |-> O_BUSY [*8])
		else $error("busy missing after program start");
	a_prot_hold: assert property ($fell(O_READ_PROT) || $fell(O_WRITE_PROT)
		|-> $past(O_BUSY))
		else $error("protection dropped outside an operation");
	a_id_prot: assert property (I_RD && O_ID_MODE && !O_BUSY &&
		I_ADDR[11:0] == 12'h77E
		|=> O_RDATA[7:0] == {{4{!O_READ_PROT}}, {4{!O_WRITE_PROT}}})
		else $error("protect status read wrong");
	a_id_noarr: assert property (I_RD && O_ID_MODE && !O_BUSY &&
		I_ADDR[11:0] != 12'h77E && I_ADDR[7:0] > 8'h04 |=> O_RDATA == 16'h0000)
		else $error("array data leaked in id mode");
endmodule
bind fip_seq fip_seq_props i_fip_seq_props (.*);
`default_nettype wire

//--- dv/fip_arr_model.sv
// behavioural flash array beside the sequencer
`default_nettype none
module fip_arr_model (
	input wire logic i_clock,
	input wire logic [23:0] i_addr,
	output logic [15:0] o_data,
	input wire logic i_pgm,
	input wire logic [23:0] i_pgm_addr,
	input wire logic [15:0] i_pgm_data,
	input wire logic i_sect_erase,
	input wire logic [11:0] i_sect,
	input wire logic i_chip_erase
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [16];
	// only 32 bytes are modelled to keep the bench small; the rest reads blank
	assign o_data = (i_addr[23:5] == 19'h0) ? mem[i_addr[4:1]] : 16'hFFFF;
	initial for (int i = 0; i < 16; i++) mem[i] = 16'h1230 + 16'(i);
	always @(posedge i_clock) begin
		if (i_chip_erase || (i_sect_erase && i_sect == 12'h000)) begin
			for (int i = 0; i < 16; i++) mem[i] = 16'hFFFF;
		end else if (i_pgm && i_pgm_addr[23:5] == 19'h0) begin
			// a cell only loses ones when programmed
			mem[i_pgm_addr[4:1]] = mem[i_pgm_addr[4:1]] & i_pgm_data;
		end
	end
endmodule
`default_nettype wire

//--- dv/fip_seq_tb_top.sv
// self-checking bench of the flash sequencer
`default_nettype none
module fip_seq_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, byt = 1'b0;
	logic pgmr = 1'b0, boot = 1'b0;
	logic [23:0] addr = 24'h000000, arr_addr, pgm_addr;
	logic [15:0] wdata = 16'h0000, rdata, arr_data, pgm_data;
	logic [11:0] sect;
	logic rd_blk, wr_blk, boot_blk, brom, alt, pgm, sect_er, chip_er;
	logic busy, id_mode, rprot, wprot;
	int n_errors = 0, checks_done = 0;
	always #10 clk = ~clk;
	fip_seq #(.SECT_ERASE_CYC(200), .CHIP_ERASE_CYC(400)) i_fip_seq (
		.I_CLOCK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd), .I_BYTE(byt), .O_RDATA(rdata),
		.I_PGMR_MODE(pgmr), .I_BOOT_MODE(boot), .O_PGMR_RD_BLOCK(rd_blk),
		.O_PGMR_WR_BLOCK(wr_blk), .O_BOOT_CMD_BLOCK(boot_blk),
		.O_BOOTROM_OVER_VECT(brom), .O_FLASH_ALT_MAP(alt),
		.O_ARR_ADDR(arr_addr), .I_ARR_DATA(arr_data), .O_ARR_PGM(pgm),
		.O_ARR_PGM_ADDR(pgm_addr), .O_ARR_PGM_DATA(pgm_data),
		.O_ARR_SECT_ERASE(sect_er), .O_ARR_SECT(sect),
		.O_ARR_CHIP_ERASE(chip_er), .O_BUSY(busy), .O_ID_MODE(id_mode),
		.O_READ_PROT(rprot), .O_WRITE_PROT(wprot));
	fip_arr_model i_fip_arr_model (.i_clock(clk), .i_addr(arr_addr),
		.o_data(arr_data), .i_pgm(pgm), .i_pgm_addr(pgm_addr),
		.i_pgm_data(pgm_data), .i_sect_erase(sect_er), .i_sect(sect),
		.i_chip_erase(chip_er));
	task automatic chk(input string what, input logic [15:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr1(input logic [23:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= {8'h07, d};
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic seq3(input logic [7:0] d);
		wr1(12'hAAA, 8'hAA);
		wr1(12'h554, 8'h55);
		wr1(12'hAAA, d);
	endtask
	task automatic rdc(string what, logic [23:0] a, logic b, logic [15:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		byt <= b;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(what, e, rdata);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 5000) begin
			@(posedge clk);
			#1 n++;
		end
		chk("busy end", 16'h0000, {15'h0, busy});
	endtask
	task automatic t_read();
		rdc("word read", 24'h000004, 1'b0, 16'h1232);
		rdc("byte read", 24'h000005, 1'b1, 16'h0012);
		rdc("byte even", 24'h000004, 1'b1, 16'h0032);
		$display("test t_read done");
	endtask
	task automatic t_id();
		seq3(8'h90);
		rdc("vendor", 24'h000000, 1'b0, 16'h005A);
		rdc("macro", 24'h000002, 1'b0, 16'h0011);
		rdc("size", 24'h000004, 1'b0, 16'h0022);
		rdc("prot free", 24'h00077E, 1'b0, 16'h00FF);
		rdc("no array", 24'h000010, 1'b0, 16'h0000);
		wr1(12'h000, 8'hF0);
		rdc("exit short", 24'h000004, 1'b0, 16'h1232);
		seq3(8'h90);
		seq3(8'hF0);
		rdc("exit long", 24'h000006, 1'b0, 16'h1233);
		$display("test t_id done");
	endtask
	task automatic t_abandon();
		wr1(12'hAAA, 8'hAA);
		wr1(12'h554, 8'h12);
		wr1(12'hAAA, 8'h90);
		rdc("abandoned", 24'h000000, 1'b0, 16'h1230);
		$display("test t_abandon done");
	endtask
	task automatic t_prot(logic [7:0] d, logic [15:0] st, logic [15:0] pr,
		logic [4:0] blk);
		seq3(8'hA5);
		wr1(12'h77E, d);
		rdc("prot tgl1", 24'h00077E, 1'b0, 16'h0040);
		rdc("prot tgl2", 24'h00077E, 1'b0, 16'h0000);
		wait_idle();
		@(posedge clk);
		pgmr <= 1'b1;
		boot <= 1'b1;
		rdc("pgmr read", 24'h000004, 1'b0, pr);
		chk("blocks", {11'h0, blk},
			{11'h0, rd_blk, wr_blk, boot_blk, brom, alt});
		@(posedge clk);
		pgmr <= 1'b0;
		boot <= 1'b0;
		seq3(8'h90);
		rdc("prot state", 24'h00077E, 1'b0, st);
		wr1(12'h000, 8'hF0);
		$display("test t_prot done");
	endtask
	task automatic t_erase();
		seq3(8'h80);
		seq3(8'h10);
		rdc("erase tgl", 24'h000004, 1'b0, 16'h0040);
		repeat (415) @(posedge clk);
		rdc("settle", 24'h000004, 1'b0, 16'h0080);
		wait_idle();
		rdc("blank", 24'h000004, 1'b0, 16'hFFFF);
		chk("prot clear", 16'h0000, {14'h0, rprot, wprot});
		$display("test t_erase done");
	endtask
	task automatic t_sector();
		@(posedge clk);
		pgmr <= 1'b1;
		seq3(8'h80);
		wr1(12'hAAA, 8'hAA);
		wr1(12'h554, 8'h55);
		wr1(24'h123000, 8'h30);
		#1 chk("sect refused", 16'h0000, {15'h0, busy});
		@(posedge clk);
		pgmr <= 1'b0;
		seq3(8'h80);
		wr1(12'hAAA, 8'hAA);
		wr1(12'h554, 8'h55);
		wr1(24'h123000, 8'h30);
		#1 chk("sector", 16'h0123, {4'h0, sect});
		rdc("sect tgl", 24'h123004, 1'b0, 16'h0040);
		wait_idle();
		$display("test t_sector done");
	endtask
	task automatic t_program();
		seq3(8'hA0);
		wr1(12'h010, 8'h06);
		#1 chk("pgm addr", 16'h0010, pgm_addr[15:0]);
		rdc("pgm poll1", 24'h000010, 1'b0, 16'h00C0);
		rdc("pgm poll2", 24'h000010, 1'b0, 16'h0080);
		wait_idle();
		rdc("pgm data", 24'h000010, 1'b0, 16'h0706);
		$display("test t_program done");
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_read();
		t_id();
		t_abandon();
		t_prot(8'h0F, 16'h00F0, 16'h1232, 5'b01111);
		t_prot(8'hF0, 16'h0000, 16'h0000, 5'b11111);
		// code runs outside the array and no interrupt is ever raised
		t_sector();
		t_erase();
		t_program();
		complete_run();
	end
	// the tests need about 10000 cycles; the margin covers a slow busy
	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		complete_run();
	end
endmodule
`default_nettype wire
